//--- hdl/efpm_pkg.sv
// Package of the external feedback and phase memory register bank.
// Assumes a single system clock of 20 MHz shared by all users.
`default_nettype none
package efpm_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FB_CTRL = 8'h45;
	localparam logic [7:0] ADDR_OUT_PWR = 8'h46;
	localparam logic [7:0] ADDR_PML_IN0 = 8'h47;
	localparam logic [7:0] ADDR_PML_IN1 = 8'h48;
	localparam logic [7:0] ADDR_PML_IN2 = 8'h49;

	// ----------------------------------------------------------------
	// Reset values and field layouts
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_FB_CTRL = 8'h00;
	localparam logic [7:0] RST_OUT_PWR = 8'h00;
	localparam logic [7:0] RST_PML = 8'h02;
	localparam logic [2:0] RST_FB_RSVD = 3'h0;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	localparam int NUM_IN = 3;
	localparam int NUM_OUT = 8;
	localparam int NUM_LOOP = 2;

	// ----------------------------------------------------------------
	// Timing: one limit unit in nanoseconds and in clock cycles
	// ----------------------------------------------------------------
	localparam int SYS_CLK_PERIOD_NS = 50;
	localparam int PML_UNIT_NS = 10000;
	localparam int PML_UNIT_CYC = (PML_UNIT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int PML_CYC_W = 16;

	typedef struct packed {
		logic global_on;
		logic [2:0] reserved;
		logic [1:0] source_choice;
		logic [1:0] loop_choice;
	} efpm_fb_ctrl_s;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} efpm_req_s;
endpackage : efpm_pkg

`default_nettype wire

//--- hdl/efpm_regs.sv
// Register bank for the external feedback path, output power and phase memory limits.
// Assumes the serial configuration port front end delivers one request per cycle on sys_clk.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - The feedback loop choice field picks loop 0 (code 00) or loop 1 (code 01) for the feedback phase measurement.
// - A loop whose compensation bit is set is compensated by the feedback phase whichever loop measures it.
// - The feedback source choice field picks reference 0 to 3 by codes 00 to 11.
// - The feedback path is enabled only while the global enable bit 7 of the control register is high.
// - Each bit of the output power register puts the matching precision output in reduced power when high.
// - Each phase memory limit is an unsigned eight-bit count of 10 us units.
// - A loop whose compensation bit is low is not compensated by the feedback phase, though it still measures it when the loop choice field names it.
module efpm_regs #(
	parameter int NUM_IN = efpm_pkg::NUM_IN,
	parameter int NUM_OUT = efpm_pkg::NUM_OUT,
	parameter int NUM_LOOP = efpm_pkg::NUM_LOOP
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire efpm_pkg::efpm_req_s req,
	output logic [7:0] rdata,
	input wire logic [NUM_LOOP-1:0] loop_feedback_comp_on,
	output logic feedback_global_on,
	output logic [1:0] feedback_loop_choice,
	output logic [1:0] feedback_source_choice,
	output logic [NUM_LOOP-1:0] loop_fb_measure,
	output logic [NUM_LOOP-1:0] loop_fb_apply,
	output logic [NUM_OUT-1:0] output_low_power_bits,
	output logic [NUM_IN*8-1:0] input_phase_memory_limit,
	output logic [NUM_IN*efpm_pkg::PML_CYC_W-1:0] phase_memory_limit_cycles
);
	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	efpm_pkg::efpm_fb_ctrl_s fb_ctrl;
	logic [NUM_OUT-1:0] out_pwr;
	logic [7:0] pml [NUM_IN];
	logic [7:0] next_rdata;
	efpm_pkg::efpm_fb_ctrl_s wr_fb;

	// Write data seen through the control register's field layout.
	assign wr_fb = req.wdata;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fb_ctrl <= efpm_pkg::RST_FB_CTRL;
		end else if (req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL) begin
			fb_ctrl.global_on <= wr_fb.global_on;
			fb_ctrl.source_choice <= wr_fb.source_choice;
			fb_ctrl.loop_choice <= wr_fb.loop_choice;
			fb_ctrl.reserved <= efpm_pkg::RST_FB_RSVD;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_pwr <= NUM_OUT'(efpm_pkg::RST_OUT_PWR);
		end else if (req.wr_en && req.addr == efpm_pkg::ADDR_OUT_PWR) begin
			out_pwr <= req.wdata[NUM_OUT-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Phase memory limits, one per input reference
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_pml
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					pml[gi] <= efpm_pkg::RST_PML;
				end else if (req.wr_en && req.addr == 8'(efpm_pkg::ADDR_PML_IN0 + gi)) begin
					pml[gi] <= req.wdata;
				end
			end
			assign input_phase_memory_limit[gi*8 +: 8] = pml[gi];
			// Limit converted to system clock cycles for the phase detector.
			assign phase_memory_limit_cycles[gi*efpm_pkg::PML_CYC_W +: efpm_pkg::PML_CYC_W] =
				efpm_pkg::PML_CYC_W'(pml[gi] * efpm_pkg::PML_UNIT_CYC);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	assign feedback_global_on = fb_ctrl.global_on;
	assign feedback_loop_choice = fb_ctrl.loop_choice;
	assign feedback_source_choice = fb_ctrl.source_choice;
	assign output_low_power_bits = out_pwr;

	generate
		for (gi = 0; gi < NUM_LOOP; gi++) begin : g_loop
			// Only the loop named by the choice field measures the feedback phase.
			assign loop_fb_measure[gi] = fb_ctrl.global_on && fb_ctrl.loop_choice == 2'(gi);
			// Compensation follows each loop's own bit, not the measuring loop.
			assign loop_fb_apply[gi] = fb_ctrl.global_on && loop_feedback_comp_on[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// A read in the same cycle as a write returns the value held before that write.
	always_comb begin
		next_rdata = efpm_pkg::RDATA_UNMAPPED;
		if (req.addr == efpm_pkg::ADDR_FB_CTRL) begin
			next_rdata = fb_ctrl;
		end else if (req.addr == efpm_pkg::ADDR_OUT_PWR) begin
			next_rdata = 8'(out_pwr);
		end else begin
			for (int i = 0; i < NUM_IN; i++) begin
				if (req.addr == 8'(efpm_pkg::ADDR_PML_IN0 + i)) begin
					next_rdata = pml[i];
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= efpm_pkg::RDATA_UNMAPPED;
		end else if (req.rd_en) begin
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_LOOP_SEL: assert property (req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL && req.wdata[7]
		&& req.wdata[1:0] == 2'h1 |=> loop_fb_measure == 2'h2)
		else $error("Loop choice 01 did not select loop 1.");
	AST_APPLY_ANY: assert property (feedback_global_on && loop_feedback_comp_on[0]
		&& feedback_loop_choice == 2'h1 |-> loop_fb_apply[0])
		else $error("Loop 0 not compensated while loop 1 measures.");
	AST_SRC_SEL: assert property (req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL
		|=> feedback_source_choice == $past(req.wdata[3:2]))
		else $error("Feedback source choice not taken from bits 3:2.");
	AST_GLOBAL_OFF: assert property (!feedback_global_on |-> loop_fb_apply == '0 && loop_fb_measure == '0)
		else $error("Feedback path active while globally disabled.");
	AST_GLOBAL_WR: assert property (req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL
		|=> feedback_global_on == $past(req.wdata[7]))
		else $error("Global enable not taken from bit 7.");
	AST_PWR_WR: assert property (req.wr_en && req.addr == efpm_pkg::ADDR_OUT_PWR
		|=> output_low_power_bits == $past(req.wdata))
		else $error("Output power bits not updated by write.");
	AST_PML_HOLD: assert property (!(req.wr_en && req.addr == efpm_pkg::ADDR_PML_IN1)
		|=> $stable(input_phase_memory_limit[15:8]))
		else $error("Phase memory limit changed without a write.");
	AST_PML_CYC: assert property (phase_memory_limit_cycles[15:0] == 16'(input_phase_memory_limit[7:0] * 200))
		else $error("Phase memory limit cycles not 200 per unit.");
	AST_COMP_OFF: assert property (!loop_feedback_comp_on[1] |-> !loop_fb_apply[1])
		else $error("Loop 1 uses feedback with its bit low.");
	AST_RSVD_RD: assert property (req.rd_en && req.addr == efpm_pkg::ADDR_FB_CTRL ##1 1'b1
		|-> rdata[6:4] == 3'h0 && rdata[7] == $past(feedback_global_on))
		else $error("Reserved control bits did not read as reset value.");
	AST_RSVD_ZERO: assert property (req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL
		|=> fb_ctrl.reserved == 3'h0)
		else $error("Reserved control bits took written data.");

	// Loop selection and compensation are independent of each other.
	AST_LOOP0_SEL: assert property (req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL && req.wdata[7]
		&& req.wdata[1:0] == 2'h0 |=> loop_fb_measure == 2'h1)
		else $error("Loop choice 00 did not select loop 0.");
	AST_LOOP_NONE: assert property (req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL
		&& req.wdata[1] |=> loop_fb_measure == 2'h0)
		else $error("A loop measures under an unused loop choice code.");
	AST_LOOP_WR: assert property (req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL
		|=> feedback_loop_choice == $past(req.wdata[1:0]))
		else $error("Loop choice not taken from bits 1:0.");
	AST_APPLY_ANY1: assert property (feedback_global_on && loop_feedback_comp_on[1]
		&& feedback_loop_choice == 2'h0 |-> loop_fb_apply[1])
		else $error("Loop 1 not compensated while loop 0 measures.");
	AST_APPLY_OWN: assert property (feedback_global_on && loop_feedback_comp_on[0] |-> loop_fb_apply[0])
		else $error("Loop 0 not compensated with its bit set.");
	AST_COMP_OFF0: assert property (!loop_feedback_comp_on[0] |-> !loop_fb_apply[0])
		else $error("Loop 0 uses feedback with its bit low.");

	// Registers move only on a write to their own address.
	AST_FB_HOLD: assert property (!(req.wr_en && req.addr == efpm_pkg::ADDR_FB_CTRL)
		|=> $stable(feedback_source_choice) && $stable(feedback_global_on)
		&& $stable(feedback_loop_choice))
		else $error("Feedback control changed without a write.");
	AST_PWR_HOLD: assert property (!(req.wr_en && req.addr == efpm_pkg::ADDR_OUT_PWR)
		|=> $stable(output_low_power_bits))
		else $error("Output power bits changed without a write.");
	AST_RD_PWR: assert property (req.rd_en && req.addr == efpm_pkg::ADDR_OUT_PWR
		|=> rdata == 8'($past(output_low_power_bits)))
		else $error("Output power register read back wrong.");

	// ----------------------------------------------------------------
	// Per-reference limit checks
	// ----------------------------------------------------------------
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_pml_chk
			// Each limit is written, read back and scaled at its own address.
			AST_PML_WR: assert property (req.wr_en && req.addr == 8'(efpm_pkg::ADDR_PML_IN0 + gi)
				|=> input_phase_memory_limit[gi*8 +: 8] == $past(req.wdata))
				else $error("Phase memory limit not updated by write.");
			AST_PML_RD: assert property (req.rd_en && req.addr == 8'(efpm_pkg::ADDR_PML_IN0 + gi)
				|=> rdata == $past(input_phase_memory_limit[gi*8 +: 8]))
				else $error("Phase memory limit read back wrong.");
			AST_PML_CYC_EACH: assert property (32'(phase_memory_limit_cycles[gi*16 +: 16])
				== 32'(input_phase_memory_limit[gi*8 +: 8]) * 200)
				else $error("Phase memory limit cycles wrong for this reference.");
		end
	endgenerate

	COV_FB_ON: cover property (feedback_global_on && loop_fb_apply == 2'h3);
	COV_PWR_ALL: cover property (output_low_power_bits == 8'hFF);
	COV_RD_PML: cover property (req.rd_en && req.addr == efpm_pkg::ADDR_PML_IN2 ##1 rdata != efpm_pkg::RST_PML);
	COV_LOOP1_MEAS: cover property (loop_fb_measure == 2'h2 && feedback_source_choice == 2'h3);
	COV_COMP_SPLIT: cover property (loop_fb_measure == 2'h1 && loop_fb_apply == 2'h2);
endmodule : efpm_regs

`default_nettype wire

//--- test/efpm_regs_test.sv
// Self-checking bench for the feedback and phase memory register bank.
// Assumes the bench drives the parallel strobe port directly at 20 MHz.
`timescale 1ns/1ps
`default_nettype none
module efpm_regs_test;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	efpm_pkg::efpm_req_s req = '0;
	logic [1:0] loop_feedback_comp_on = 2'h0;
	logic [7:0] rdata;
	logic on;
	logic [1:0] lc, sc, meas, app;
	logic [7:0] lp;
	logic [23:0] pml;
	logic [47:0] cyc;
	int n_mismatch = 0;
	int n_compared = 0;
	localparam int UNIT = 10000 / 50;
	efpm_regs efpm_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
		.loop_feedback_comp_on(loop_feedback_comp_on), .feedback_global_on(on), .feedback_loop_choice(lc),
		.feedback_source_choice(sc), .loop_fb_measure(meas), .loop_fb_apply(app),
		.output_low_power_bits(lp), .input_phase_memory_limit(pml), .phase_memory_limit_cycles(cyc));
	always #25 sys_clk = ~sys_clk;
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk);
		req <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge sys_clk);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk);
		req <= '0;
		#1;
		check(what, 24'(rdata), 24'(exp));
	endtask : rd
	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic test_reset;
		rd(efpm_pkg::ADDR_FB_CTRL, efpm_pkg::RST_FB_CTRL, "fb_ctrl");
		rd(efpm_pkg::ADDR_OUT_PWR, efpm_pkg::RST_OUT_PWR, "out_pwr");
		for (int i = 0; i < 3; i++) begin
			rd(efpm_pkg::ADDR_PML_IN0 + 8'(i), efpm_pkg::RST_PML, "pml_rst");
			check("cyc_rst", 24'(cyc[i*16 +: 16]), 24'(efpm_pkg::RST_PML * UNIT));
		end
		check("meas_rst", 24'({meas, app}), 24'h0);
		$display("Test reset done");
	endtask : test_reset
	task automatic test_fb;
		@(posedge sys_clk);
		loop_feedback_comp_on <= 2'h2;
		for (int s = 0; s < 4; s++)
			for (int l = 0; l < 2; l++) begin
				wr(efpm_pkg::ADDR_FB_CTRL, {1'b1, 3'h7, 2'(s), 2'(l)});
				check("src", 24'(sc), 24'(s));
				check("loop", 24'(lc), 24'(l));
				check("meas", 24'(meas), 24'(2'h1 << l));
				check("apply", 24'({on, app}), 24'h6);
			end
		rd(efpm_pkg::ADDR_FB_CTRL, 8'h8D, "rsvd");
		wr(efpm_pkg::ADDR_FB_CTRL, 8'h82);
		check("meas_10", 24'(meas), 24'h0);
		wr(efpm_pkg::ADDR_FB_CTRL, 8'h05);
		check("off", 24'({on, meas, app}), 24'h0);
		@(posedge sys_clk);
		loop_feedback_comp_on <= 2'h1;
		wr(efpm_pkg::ADDR_FB_CTRL, 8'h81);
		check("apply0", 24'(app), 24'h1);
		$display("Test feedback done");
	endtask : test_fb
	task automatic test_pwr_pml;
		for (int i = 0; i < 8; i++) begin
			wr(efpm_pkg::ADDR_OUT_PWR, 8'h01 << i);
			check("pwr", 24'(lp), 24'(8'h01 << i));
		end
		for (int i = 0; i < 3; i++) begin
			wr(efpm_pkg::ADDR_PML_IN0 + 8'(i), 8'hFF - 8'(i));
			check("pml", 24'(pml[i*8 +: 8]), 24'(8'hFF - 8'(i)));
			check("cyc", 24'(cyc[i*16 +: 16]), 24'((255 - i) * UNIT));
		end
		rd(efpm_pkg::ADDR_PML_IN2, 8'hFD, "pml_rd");
		wr(8'h4A, 8'h55);
		rd(8'h4A, efpm_pkg::RDATA_UNMAPPED, "unmapped");
		rd(efpm_pkg::ADDR_OUT_PWR, 8'h80, "pwr_rd");
		$display("Test power and limits done");
	endtask : test_pwr_pml
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		test_reset();
		test_fb();
		test_pwr_pml();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		test_reset();
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		stop_test();
	end
endmodule : efpm_regs_test
`default_nettype wire
